// ===== src/snc_node_regs.sv
`timescale 1ns/1ps
module snc_node_regs #(
  parameter logic [7:0]  SWITCH_REVISION  = 8'h01, // Arbitrary value
  parameter logic [7:0]  SWITCH_VERSION   = 8'h01, // Arbitrary value
  parameter logic [7:0]  NUM_LINKS        = 8'h08,
  parameter logic [7:0]  NUM_PROCS_SWITCH = 8'h02,
  parameter logic [7:0]  NUM_PROCS_DEVICE = 8'h02,
  parameter logic [31:0] JTAG_ID          = 32'h0000_0001, // Arbitrary value
  parameter logic [31:0] USERCODE         = 32'h0000_0000  // Arbitrary value
)(
  input  wire logic                  core_clk,
  input  wire logic                  rst,
  input  wire snc_pkg::snc_cfg_req_s cfg_req,
  output logic                       cfg_ready,
  output snc_pkg::snc_cfg_rsp_s      cfg_rsp,
  input  wire logic [7:0]            boot_select_pins,
  input  wire logic                  pll_locked,
  output snc_pkg::snc_pll_ctl_s      pll_ctl,
  output logic                       tile_reset,
  output logic                       header_one_byte,
  output logic [15:0]                node_id,
  output logic [15:0]                switch_clk_div,
  output logic [15:0]                ref_clk_div,
  output logic [63:0]                route_directions
);
  import snc_pkg::*;

  snc_state_e   state_q;
  logic [7:0]   settle_q;
  logic         ready_q;
  snc_cfg_rsp_s rsp_q;
  logic [31:0]  swcfg_q;
  logic [15:0]  node_id_q;
  logic [31:0]  pll_q;
  logic         tile_reset_q;
  logic [15:0]  sw_div_q;
  logic [15:0]  ref_div_q;
  logic [31:0]  dir_lo_q;
  logic [31:0]  dir_hi_q;
  logic [1:0]   dbg_cfg_q [2];
  logic [31:0]  link_stat_q [LINK_STAT_NUM];
  logic [31:0]  link_cfg_q [LINK_CFG_NUM];
  logic [31:0]  static_cfg_q [STATIC_CFG_NUM];
  logic [7:0]   boot_s1_q;
  logic [7:0]   boot_s2_q;
  logic [7:0]   boot_cap_q;
  logic [1:0]   cap_cnt_q;
  logic         lock_s1_q;
  logic         lock_s2_q;

  logic         take;
  logic         wr_take;
  logic         mapped;
  logic         read_only;
  logic         wr_ok;
  logic         pll_wr_ok;
  logic [31:0]  rdata;
  logic [3:0]   link_idx;

  // True when addr falls in a block of count registers starting at base
  function automatic logic in_range(input logic [7:0] addr, input logic [7:0] base, input int count);
    logic [7:0] ofs;
    ofs = addr - base;
    in_range = (addr >= base) && (int'(ofs) < count);
  endfunction : in_range

  // Request is taken only while ready; the bank is a plain config target
  assign take    = cfg_req.valid && ready_q;
  assign wr_take = take && cfg_req.write;
  assign link_idx = cfg_req.addr[3:0];

  // Address decode and read mux; unmapped and reserved bits read zero
  always_comb
  begin
    mapped    = 1'b1;
    read_only = 1'b0;
    rdata     = 32'h0000_0000;
    if (in_range(cfg_req.addr, OFS_LINK_STAT, LINK_STAT_NUM))
      rdata = link_stat_q[link_idx];
    else if (in_range(cfg_req.addr, OFS_LINK_CFG, LINK_CFG_NUM))
      rdata = link_cfg_q[link_idx];
    else if (in_range(cfg_req.addr, OFS_STATIC_CFG, STATIC_CFG_NUM))
      rdata = static_cfg_q[link_idx[2:0]];
    else
    begin
      unique case (cfg_req.addr)
        OFS_IDENT:
        begin
          rdata     = {8'h00, boot_cap_q, SWITCH_REVISION, SWITCH_VERSION};
          read_only = 1'b1;
        end
        OFS_DESCR:
        begin
          rdata     = {8'h00, NUM_LINKS, NUM_PROCS_SWITCH, NUM_PROCS_DEVICE};
          read_only = 1'b1;
        end
        OFS_SWCFG:    rdata = swcfg_q;
        OFS_NODE_ID:  rdata = {16'h0000, node_id_q};
        OFS_PLL:      rdata = pll_q; // Bypass and JTAG boot bits are write-only, never stored
        OFS_SW_DIV:   rdata = {16'h0000, sw_div_q};
        OFS_REF_DIV:  rdata = {16'h0000, ref_div_q};
        OFS_JTAG_ID:
        begin
          rdata     = JTAG_ID;
          read_only = 1'b1;
        end
        OFS_USERCODE:
        begin
          rdata     = USERCODE;
          read_only = 1'b1;
        end
        OFS_DIR_LO:   rdata = dir_lo_q;
        OFS_DIR_HI:   rdata = dir_hi_q;
        OFS_DBG_CFG0: rdata = {30'h0000_0000, dbg_cfg_q[0]};
        OFS_DBG_CFG1: rdata = {30'h0000_0000, dbg_cfg_q[1]};
        default:      mapped = 1'b0;
      endcase
    end
  end

  // Lock-all also covers the configuration register itself: only reset unlocks
  assign wr_ok = wr_take && mapped && !read_only && !swcfg_q[SWCFG_LOCK_ALL_BIT];
  assign pll_wr_ok = wr_ok && (cfg_req.addr == OFS_PLL) && !swcfg_q[SWCFG_LOCK_PLL_BIT];

  // Answer one cycle after the request; refused writes flag an error
  always_ff @(posedge core_clk)
  begin
    if (rst)
      rsp_q <= '0;
    else
    begin
      rsp_q.ack   <= take;
      rsp_q.rdata <= (take && !cfg_req.write) ? rdata : 32'h0000_0000;
      rsp_q.err   <= take && (!mapped || (cfg_req.write && (read_only || !wr_ok ||
                     ((cfg_req.addr == OFS_PLL) && !pll_wr_ok))));
    end
  end

  // Switch configuration and node identifier
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      swcfg_q   <= 32'h0000_0000;
      node_id_q <= 16'h0000;
    end
    else if (wr_ok && cfg_req.addr == OFS_SWCFG)
      swcfg_q <= cfg_req.wdata & SWCFG_WMASK;
    else if (wr_ok && cfg_req.addr == OFS_NODE_ID)
      node_id_q <= cfg_req.wdata[15:0];
  end

  // PLL settings: dividers stored, debug strobes only drive the PLL outputs
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      pll_q        <= 32'h0000_0000;
      pll_ctl      <= '0;
      tile_reset_q <= 1'b0;
    end
    else
    begin
      tile_reset_q <= pll_wr_ok && !cfg_req.wdata[PLL_NO_RESET_BIT];
      if (pll_wr_ok)
      begin
        pll_q <= cfg_req.wdata & ~((32'h0000_0001 << PLL_BYPASS_BIT) | (32'h0000_0001 << PLL_JTAG_BOOT_BIT) |
                 PLL_RSVD_MASK);
        pll_ctl.bypass    <= cfg_req.wdata[PLL_BYPASS_BIT];
        pll_ctl.jtag_boot <= cfg_req.wdata[PLL_JTAG_BOOT_BIT];
        pll_ctl.out_div   <= cfg_req.wdata[PLL_OD_LSB +: PLL_OD_W];
        pll_ctl.fb_mul    <= cfg_req.wdata[PLL_FB_LSB +: PLL_FB_W];
        pll_ctl.in_div    <= cfg_req.wdata[PLL_ID_LSB +: PLL_ID_W];
      end
    end
  end

  // Clock dividers
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      sw_div_q  <= SW_DIV_RST;
      ref_div_q <= REF_DIV_RST;
    end
    else if (wr_ok && cfg_req.addr == OFS_SW_DIV)
      sw_div_q <= cfg_req.wdata[15:0];
    else if (wr_ok && cfg_req.addr == OFS_REF_DIV)
      ref_div_q <= cfg_req.wdata[15:0];
  end

  // Routing directions and debug pin configuration
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      dir_lo_q     <= 32'h0000_0000;
      dir_hi_q     <= 32'h0000_0000;
      dbg_cfg_q[0] <= 2'h0;
      dbg_cfg_q[1] <= 2'h0;
    end
    else if (wr_ok)
    begin
      if (cfg_req.addr == OFS_DIR_LO)
        dir_lo_q <= cfg_req.wdata;
      if (cfg_req.addr == OFS_DIR_HI)
        dir_hi_q <= cfg_req.wdata;
      if (cfg_req.addr == OFS_DBG_CFG0)
        dbg_cfg_q[0] <= cfg_req.wdata[1:0];
      if (cfg_req.addr == OFS_DBG_CFG1)
        dbg_cfg_q[1] <= cfg_req.wdata[1:0];
    end
  end

  // Link register arrays
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      for (int i = 0; i < LINK_STAT_NUM; i++)
        link_stat_q[i] <= 32'h0000_0000;
      for (int i = 0; i < LINK_CFG_NUM; i++)
        link_cfg_q[i] <= 32'h0000_0000;
      for (int i = 0; i < STATIC_CFG_NUM; i++)
        static_cfg_q[i] <= 32'h0000_0000;
    end
    else if (wr_ok)
    begin
      if (in_range(cfg_req.addr, OFS_LINK_STAT, LINK_STAT_NUM))
        link_stat_q[link_idx] <= cfg_req.wdata & LINK_STAT_WMASK;
      if (in_range(cfg_req.addr, OFS_LINK_CFG, LINK_CFG_NUM))
        link_cfg_q[link_idx] <= cfg_req.wdata;
      if (in_range(cfg_req.addr, OFS_STATIC_CFG, STATIC_CFG_NUM))
        static_cfg_q[link_idx[2:0]] <= cfg_req.wdata;
    end
  end

  // Boot pins synchronised, then caught once after reset release
  always_ff @(posedge core_clk)
  begin
    boot_s1_q <= boot_select_pins;
    boot_s2_q <= boot_s1_q;
    lock_s1_q <= pll_locked;
    lock_s2_q <= lock_s1_q;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      cap_cnt_q  <= 2'h0;
      boot_cap_q <= 8'h00;
    end
    else if (int'(cap_cnt_q) < BOOT_CAP_DELAY)
      cap_cnt_q <= cap_cnt_q + 2'h1; // Let the synchroniser fill first
    else if (int'(cap_cnt_q) == BOOT_CAP_DELAY)
    begin
      boot_cap_q <= boot_s2_q;
      cap_cnt_q  <= cap_cnt_q + 2'h1;
    end
  end

  // Re-lock wait: lock may still read high from the old setting, so settle first
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      state_q  <= ST_IDLE;
      settle_q <= 8'h00;
      ready_q  <= 1'b0;
    end
    else
    begin
      unique case (state_q)
        ST_IDLE:
        begin
          ready_q <= 1'b1;
          if (pll_wr_ok && !cfg_req.wdata[PLL_NO_WAIT_BIT])
          begin
            state_q  <= ST_SETTLE;
            settle_q <= 8'(PLL_SETTLE_CYC - 1);
            ready_q  <= 1'b0;
          end
        end
        ST_SETTLE:
        begin
          settle_q <= settle_q - 8'h01;
          if (settle_q == 8'h00)
            state_q <= ST_WAIT_LOCK;
        end
        ST_WAIT_LOCK:
        begin
          if (lock_s2_q)
          begin
            state_q <= ST_IDLE;
            ready_q <= 1'b1;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  assign cfg_ready        = ready_q;
  assign cfg_rsp          = rsp_q;
  assign tile_reset       = tile_reset_q;
  assign header_one_byte  = swcfg_q[SWCFG_HDR_BIT];
  assign node_id          = node_id_q;
  assign switch_clk_div   = sw_div_q;
  assign ref_clk_div      = ref_div_q;
  assign route_directions = {dir_hi_q, dir_lo_q};

  // Checks
  sequence s_pll_wr;
    pll_wr_ok;
  endsequence

  property p_ack_next;
    @(posedge core_clk) disable iff (rst) take |=> cfg_rsp.ack;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("answer missing after request");

  property p_ident;
    @(posedge core_clk) disable iff (rst)
      take && !cfg_req.write && cfg_req.addr == OFS_IDENT
      |=> cfg_rsp.rdata[15:0] == {SWITCH_REVISION, SWITCH_VERSION} && cfg_rsp.rdata[31:24] == 8'h00;
  endproperty
  a_ident: assert property (p_ident) else $error("identification read wrong");

  property p_descr;
    @(posedge core_clk) disable iff (rst)
      take && !cfg_req.write && cfg_req.addr == OFS_DESCR |=> cfg_rsp.rdata[23:16] == NUM_LINKS;
  endproperty
  a_descr: assert property (p_descr) else $error("description read wrong");

  property p_lock_all;
    @(posedge core_clk) disable iff (rst)
      wr_take && swcfg_q[SWCFG_LOCK_ALL_BIT] && cfg_req.addr == OFS_NODE_ID
      |=> $stable(node_id_q) && cfg_rsp.err;
  endproperty
  a_lock_all: assert property (p_lock_all) else $error("write passed the lock");

  property p_lock_pll;
    @(posedge core_clk) disable iff (rst)
      wr_take && swcfg_q[SWCFG_LOCK_PLL_BIT] && cfg_req.addr == OFS_PLL
      |=> !tile_reset && $stable(pll_q);
  endproperty
  a_lock_pll: assert property (p_lock_pll) else $error("PLL write passed its lock");

  property p_tile_reset;
    @(posedge core_clk) disable iff (rst)
      s_pll_wr ##0 !cfg_req.wdata[PLL_NO_RESET_BIT] |=> tile_reset ##1
        (!tile_reset || $past(pll_wr_ok && !cfg_req.wdata[PLL_NO_RESET_BIT]));
  endproperty
  a_tile_reset: assert property (p_tile_reset) else $error("tile reset not pulsed");

  property p_no_reset;
    @(posedge core_clk) disable iff (rst)
      s_pll_wr ##0 cfg_req.wdata[PLL_NO_RESET_BIT] |=> !tile_reset;
  endproperty
  a_no_reset: assert property (p_no_reset) else $error("tile reset despite bit 31");

  property p_relock;
    @(posedge core_clk) disable iff (rst)
      s_pll_wr ##0 !cfg_req.wdata[PLL_NO_WAIT_BIT] |=> !cfg_ready [*8];
  endproperty
  a_relock: assert property (p_relock) else $error("ready during re-lock wait");

  property p_node_rsvd;
    @(posedge core_clk) disable iff (rst)
      take && !cfg_req.write && cfg_req.addr == OFS_NODE_ID |=> cfg_rsp.rdata[31:16] == 16'h0000;
  endproperty
  a_node_rsvd: assert property (p_node_rsvd) else $error("reserved bits not zero");

  property p_ref_reset;
    @(posedge core_clk) rst ##1 !rst |-> ref_clk_div == REF_DIV_RST;
  endproperty
  a_ref_reset: assert property (p_ref_reset) else $error("reference divider reset wrong");

endmodule : snc_node_regs

// ===== include/snc_pkg.sv
// Contract
// - Registers reached only by configuration reads/writes
// - Identification: boot pins, revision, version fields
// - Description: links, switch processors, device processors
// - Lock bit 31 rejects all control writes
// - Bit 8 blocks PLL settings writes
// - Bit 0 selects one-byte or two-byte headers
// - Sixteen-bit node number, upper bits reserved
// - PLL multiplies input clock for whole node
// - Accepted PLL write resets tile
// - PLL bit 31 set skips the reset
// - PLL bit 30 set skips re-lock wait
// - PLL bit 29 write puts PLL in bypass
// - PLL bit 28 write selects JTAG boot
// - Output divider bits 25:23, value plus one
// - Feedback multiplier bits 20:8, value plus one
// - Input divider bits 6:0, value plus one
// - Switch and reference clock dividers at 0x07/0x08
// - Link config from 0x80, static from 0xA0
// - Reference divider bits 15:0 reset three
package snc_pkg;

  // Register offsets (configuration register numbers)
  localparam logic [7:0] OFS_IDENT      = 8'h00;
  localparam logic [7:0] OFS_DESCR      = 8'h01;
  localparam logic [7:0] OFS_SWCFG      = 8'h04;
  localparam logic [7:0] OFS_NODE_ID    = 8'h05;
  localparam logic [7:0] OFS_PLL        = 8'h06;
  localparam logic [7:0] OFS_SW_DIV     = 8'h07;
  localparam logic [7:0] OFS_REF_DIV    = 8'h08;
  localparam logic [7:0] OFS_JTAG_ID    = 8'h09;
  localparam logic [7:0] OFS_USERCODE   = 8'h0a;
  localparam logic [7:0] OFS_DIR_LO     = 8'h0c;
  localparam logic [7:0] OFS_DIR_HI     = 8'h0d;
  localparam logic [7:0] OFS_DBG_CFG0   = 8'h10;
  localparam logic [7:0] OFS_DBG_CFG1   = 8'h11;
  localparam logic [7:0] OFS_LINK_STAT  = 8'h20;
  localparam logic [7:0] OFS_LINK_CFG   = 8'h80;
  localparam logic [7:0] OFS_STATIC_CFG = 8'ha0;
  localparam int         LINK_STAT_NUM  = 9;
  localparam int         LINK_CFG_NUM   = 9;
  localparam int         STATIC_CFG_NUM = 8;

  // Switch configuration field positions
  localparam int SWCFG_LOCK_ALL_BIT = 31;
  localparam int SWCFG_LOCK_PLL_BIT = 8;
  localparam int SWCFG_HDR_BIT      = 0;

  // PLL settings field positions
  localparam int PLL_NO_RESET_BIT  = 31;
  localparam int PLL_NO_WAIT_BIT   = 30;
  localparam int PLL_BYPASS_BIT    = 29;
  localparam int PLL_JTAG_BOOT_BIT = 28;
  localparam int PLL_OD_LSB        = 23;
  localparam int PLL_FB_LSB        = 8;
  localparam int PLL_ID_LSB        = 0;
  localparam int PLL_OD_W          = 3;
  localparam int PLL_FB_W          = 13;
  localparam int PLL_ID_W          = 7;

  // Write masks: reserved bits are never stored
  localparam logic [31:0] SWCFG_WMASK     = 32'h8000_0101;
  localparam logic [31:0] NODE_ID_WMASK   = 32'h0000_ffff;
  localparam logic [31:0] DIV_WMASK       = 32'h0000_ffff;
  localparam logic [31:0] DBG_CFG_WMASK   = 32'h0000_0003;
  localparam logic [31:0] LINK_STAT_WMASK = 32'h0000_0f30;
  localparam logic [31:0] PLL_RSVD_MASK   = 32'h0c60_0080;

  // Reset values
  localparam logic [15:0] SW_DIV_RST  = 16'h0000;
  localparam logic [15:0] REF_DIV_RST = 16'h0003;

  // Timing: settle time before PLL lock is believed, rounded up to cycles
  localparam int CLK_PERIOD_NS   = 20;
  localparam int PLL_SETTLE_NS   = 1000;
  localparam int PLL_SETTLE_CYC  = (PLL_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BOOT_CAP_DELAY  = 2;

  typedef enum logic [1:0]
  {
    ST_IDLE      = 2'b00,
    ST_SETTLE    = 2'b01,
    ST_WAIT_LOCK = 2'b11
  } snc_state_e;

  typedef struct packed
  {
    logic        valid;
    logic        write;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } snc_cfg_req_s;

  typedef struct packed
  {
    logic        ack;
    logic        err;
    logic [31:0] rdata;
  } snc_cfg_rsp_s;

  typedef struct packed
  {
    logic                bypass;
    logic                jtag_boot;
    logic [PLL_OD_W-1:0] out_div;
    logic [PLL_FB_W-1:0] fb_mul;
    logic [PLL_ID_W-1:0] in_div;
  } snc_pll_ctl_s;

endpackage : snc_pkg

// ===== tb/snc_cfg_requester.sv
`timescale 1ns/1ps
module snc_cfg_requester (
  input  wire logic                  core_clk,
  input  wire logic                  cfg_ready,
  input  wire snc_pkg::snc_cfg_rsp_s cfg_rsp,
  output snc_pkg::snc_cfg_req_s      cfg_req,
  output logic                       pll_locked
);
  import snc_pkg::*;
  logic [6:0] lock_cnt_q = 7'h00;
  logic       last_pll   = 1'b0;
  logic       relock_d;

  initial cfg_req = '0;

  // Only an accepted PLL write that waits for lock makes the PLL retune
  assign relock_d = cfg_rsp.ack && !cfg_rsp.err && last_pll;

  // PLL stand-in: lock is lost for 60 cycles after a retune
  always @(posedge core_clk)
  begin
    if (relock_d)
      lock_cnt_q <= 7'h3c;
    else if (lock_cnt_q != 7'h00)
      lock_cnt_q <= lock_cnt_q - 7'h01;
  end
  assign pll_locked = (lock_cnt_q == 7'h00);

  // Whole transfer: request held until taken, then released to inverted junk
  task automatic access(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                        output snc_cfg_rsp_s rsp, output logic ok);
    int n;
    ok = 1'b0;
    cfg_req <= '{valid: 1'b1, write: wr, addr: addr, wdata: wdata};
    for (n = 0; n < 200 && !ok; n++)
    begin
      @(posedge core_clk);
      ok = cfg_ready;
    end
    // Set at the taking edge, so no answer of an older request can see it
    last_pll = wr && addr == OFS_PLL && !wdata[PLL_NO_WAIT_BIT];
    cfg_req <= '{valid: 1'b0, write: ~wr, addr: ~addr, wdata: ~wdata};
    @(posedge core_clk);
    rsp = cfg_rsp;
  endtask : access
endmodule : snc_cfg_requester

// ===== tb/switch_node_config_regs_tb.sv
`timescale 1ns/1ps
module switch_node_config_regs_tb;
  import snc_pkg::*;
  localparam logic [7:0]  REV   = 8'h3c;         // Arbitrary value
  localparam logic [7:0]  VER   = 8'h2b;         // Arbitrary value
  localparam logic [31:0] JID   = 32'h1234_5678; // Arbitrary value
  localparam logic [31:0] UCODE = 32'h0bad_cafe; // Arbitrary value
  localparam logic [31:0] DESC  = 32'h0009_0203;
  logic         core_clk  = 1'b0;
  logic         rst       = 1'b1;
  logic [7:0]   boot_pins = 8'h5a;
  logic         cfg_ready;
  logic         tile_reset;
  logic         hdr_one;
  logic         pll_locked;
  logic [15:0]  node_id;
  logic [15:0]  sw_div;
  logic [15:0]  ref_div;
  logic [63:0]  route;
  snc_cfg_req_s cfg_req;
  snc_cfg_rsp_s cfg_rsp;
  snc_pll_ctl_s pll_ctl;
  int           bad_count = 0;
  int           tests_run = 0;
  int           n;
  logic [7:0]   t_a [12];
  logic [31:0]  t_d [12];
  logic [31:0]  t_v [12];
  logic [7:0]   e_a [8];
  logic [31:0]  p_d [3];

  // 50 MHz switch clock
  always #10 core_clk = ~core_clk;

  snc_node_regs #(
    .SWITCH_REVISION (REV), .SWITCH_VERSION (VER), .NUM_LINKS (DESC[23:16]),
    .NUM_PROCS_SWITCH (DESC[15:8]), .NUM_PROCS_DEVICE (DESC[7:0]), .JTAG_ID (JID), .USERCODE (UCODE)
  ) i_dut (
    .core_clk         (core_clk),
    .rst              (rst),
    .cfg_req          (cfg_req),
    .cfg_ready        (cfg_ready),
    .cfg_rsp          (cfg_rsp),
    .boot_select_pins (boot_pins),
    .pll_locked       (pll_locked),
    .pll_ctl          (pll_ctl),
    .tile_reset       (tile_reset),
    .header_one_byte  (hdr_one),
    .node_id          (node_id),
    .switch_clk_div   (sw_div),
    .ref_clk_div      (ref_div),
    .route_directions (route)
  );

  snc_cfg_requester i_req (
    .core_clk   (core_clk),
    .cfg_ready  (cfg_ready),
    .cfg_rsp    (cfg_rsp),
    .cfg_req    (cfg_req),
    .pll_locked (pll_locked)
  );

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_sim

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
      bad_count++;
    end
  endtask : chk

  // Boot pins change with reset so the capture after release is visible
  task automatic do_reset(input logic [7:0] pins);
    boot_pins <= pins;
    rst <= 1'b1;
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    repeat (4) @(posedge core_clk);
  endtask : do_reset

  // One transfer; a request never taken ends the run
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic e_err,
                      input logic [31:0] e_rd);
    snc_cfg_rsp_s rsp;
    logic         ok;
    i_req.access(wr, a, d, rsp, ok);
    if (!ok)
    begin
      $display("[FAIL] cfg_ready expected 1 seen 0");
      bad_count++;
      end_sim();
    end
    else
    begin
      chk("ack", 32'h1, {31'h0, rsp.ack});
      chk("err", {31'h0, e_err}, {31'h0, rsp.err});
      if (!wr)
        chk("rdata", e_rd, rsp.rdata);
    end
  endtask : xfer

  // PLL write: pulse, ready gap while relocking, then readback
  task automatic pll_case(input logic [31:0] d);
    int k;
    int seen;
    seen = 0;
    xfer(1'b1, OFS_PLL, d, 1'b0, 32'h0);
    chk("tile_reset", {31'h0, ~d[31]}, {31'h0, tile_reset});
    chk("cfg_ready", {31'h0, d[30]}, {31'h0, cfg_ready});
    chk("pll_ctl", {7'h0, d[29:28], d[25:23], d[20:8], d[6:0]}, {7'h0, pll_ctl});
    for (k = 0; k < 55; k++)
    begin
      @(posedge core_clk);
      if (tile_reset || cfg_ready !== d[30])
        seen++;
    end
    chk("settle_cycles", 32'h0, seen);
    for (k = 0; k < 200 && cfg_ready !== 1'b1; k++)
      @(posedge core_clk);
    chk("relock_wait", 32'h1, {31'h0, cfg_ready});
    xfer(1'b0, OFS_PLL, 32'h0, 1'b0, d & 32'hc39f_ff7f);
  endtask : pll_case

  initial
  begin
    do_reset(8'h5a);
    t_a = '{OFS_IDENT, OFS_DESCR, OFS_SWCFG, OFS_NODE_ID, OFS_PLL, OFS_SW_DIV, OFS_REF_DIV, OFS_JTAG_ID,
            OFS_USERCODE, OFS_DIR_HI, OFS_DBG_CFG0, OFS_STATIC_CFG};
    t_v = '{{8'h00, 8'h5a, REV, VER}, DESC, 32'h0, 32'h0, 32'h0, 32'h0, 32'h3, JID, UCODE, 32'h0, 32'h0, 32'h0};
    for (n = 0; n < 12; n++)
      xfer(1'b0, t_a[n], 32'h0, 1'b0, t_v[n]);
    chk("ref_clk_div", 32'h3, {16'h0, ref_div});
    chk("pll_ctl", 32'h0, {7'h0, pll_ctl});
    chk("header_one_byte", 32'h0, {31'h0, hdr_one});
    $display("Test reset_values done");

    // Writable fields, reserved bits dropped
    t_a = '{OFS_NODE_ID, OFS_SW_DIV, OFS_REF_DIV, OFS_DIR_LO, OFS_DIR_HI, OFS_DBG_CFG1, 8'h28, 8'h88, 8'ha7,
            OFS_SWCFG, OFS_SWCFG, OFS_DBG_CFG0};
    t_d = '{32'hffff_ffff, 32'hffff_ffff, 32'h1234_abcd, 32'h8765_4321, 32'h0fed_cba9, 32'hffff_ffff,
            32'hffff_ffff, 32'ha5a5_5a5a, 32'h5a5a_a5a5, 32'h7fff_fefe, 32'h0000_0001, 32'h0000_0002};
    t_v = '{32'h0000_ffff, 32'h0000_ffff, 32'h0000_abcd, 32'h8765_4321, 32'h0fed_cba9, 32'h3, 32'h0f30,
            32'ha5a5_5a5a, 32'h5a5a_a5a5, 32'h0, 32'h1, 32'h2};
    for (n = 0; n < 12; n++)
    begin
      xfer(1'b1, t_a[n], t_d[n], 1'b0, 32'h0);
      xfer(1'b0, t_a[n], 32'h0, 1'b0, t_v[n]);
    end
    chk("node_id", 32'hffff, {16'h0, node_id});
    chk("switch_clk_div", 32'hffff, {16'h0, sw_div});
    chk("ref_clk_div", 32'habcd, {16'h0, ref_div});
    chk("route_hi", 32'h0fed_cba9, route[63:32]);
    chk("route_lo", 32'h8765_4321, route[31:0]);
    chk("header_one_byte", 32'h1, {31'h0, hdr_one});
    $display("Test rw_fields done");

    // Read-only writes and unmapped places are refused
    e_a = '{OFS_IDENT, OFS_DESCR, OFS_JTAG_ID, OFS_USERCODE, 8'h1f, 8'h40, 8'h29, 8'ha8};
    for (n = 0; n < 8; n++)
      xfer(n < 4, e_a[n], 32'hffff_ffff, 1'b1, 32'h0);
    xfer(1'b0, OFS_IDENT, 32'h0, 1'b0, {8'h00, 8'h5a, REV, VER});
    $display("Test refusals done");

    p_d = '{32'h3ada_bcc5, 32'h4380_007f, 32'hc000_0100};
    for (n = 0; n < 3; n++)
      pll_case(p_d[n]);
    $display("Test pll done");

    xfer(1'b1, OFS_SWCFG, 32'h0000_0100, 1'b0, 32'h0);
    xfer(1'b1, OFS_PLL, 32'h0, 1'b1, 32'h0);
    chk("tile_reset", 32'h0, {31'h0, tile_reset});
    chk("pll_ctl", {7'h0, 2'b00, 3'h0, 13'h0001, 7'h00}, {7'h0, pll_ctl});
    xfer(1'b1, OFS_NODE_ID, 32'h0000_1234, 1'b0, 32'h0);
    xfer(1'b1, OFS_SWCFG, 32'h8000_0101, 1'b0, 32'h0);
    xfer(1'b1, OFS_NODE_ID, 32'h0000_5678, 1'b1, 32'h0);
    xfer(1'b1, 8'h88, 32'h0, 1'b1, 32'h0);
    xfer(1'b1, OFS_SWCFG, 32'h0, 1'b1, 32'h0);
    xfer(1'b0, OFS_SWCFG, 32'h0, 1'b0, 32'h8000_0101);
    chk("node_id", 32'h1234, {16'h0, node_id});
    $display("Test locks done");

    // Only a reset unlocks; pins are captured afresh
    do_reset(8'ha5);
    xfer(1'b0, OFS_IDENT, 32'h0, 1'b0, {8'h00, 8'ha5, REV, VER});
    xfer(1'b0, OFS_SWCFG, 32'h0, 1'b0, 32'h0);
    xfer(1'b1, OFS_NODE_ID, 32'h0000_5678, 1'b0, 32'h0);
    chk("node_id", 32'h5678, {16'h0, node_id});
    $display("Test second_reset done");
    end_sim();
  end
endmodule : switch_node_config_regs_tb
